// ---- hdl/sadc_params.svh ----
// timing counts, field widths and reset values of the serial converter readout
`ifndef SADC_PARAMS_SVH
`define SADC_PARAMS_SVH

`define SADC_DATA_BITS 8
`define SADC_CONV_PERIODS 4'hb
`define SADC_LEAD_PERIODS 4'h2
`define SADC_MSB_MASK 8'h80
`define SADC_CODE_RESET 8'h00
`define SADC_CNT_RESET 4'h0
`define SADC_BIT_RESET 3'h7
`define SADC_SEL_IDLE 1'b1
`define SADC_SCLK_IDLE 1'b0

`endif

// ---- hdl/sadc_pkg.sv ----
// types shared by the serial converter readout
package sadc_pkg;

   typedef enum logic [1:0] {
      SADC_SHUTDOWN,
      SADC_CONVERT,
      SADC_DONE
   } sadc_state_t;

   // serial data pin: value and output enable (high while driving)
   typedef struct packed {
      logic data;
      logic oe;
   } sadc_sout_t;

   // host-side pins as sampled at the package boundary
   typedef struct packed {
      logic sel_n;
      logic sclk;
   } sadc_pins_t;

endpackage

// ---- hdl/sadc_pin_sync.sv ----
// three-stage pin synchroniser that accepts a change once stages 2 and 3 agree
`timescale 1ns/1ps
`default_nettype none

module sadc_pin_sync #(
   parameter logic INIT = 1'b0
) (
   input wire logic ref_clk, // system clock
   input wire logic sys_rst, // synchronous reset, active high
   input wire logic pin, // asynchronous pin level
   output logic level, // filtered level
   output logic rise, // one-cycle pulse on accepted rise
   output logic fall // one-cycle pulse on accepted fall
);
   logic s1;
   logic s2;
   logic s3;
   logic next_level;

   // s1 is read by s2 only, to keep metastability away from logic
   assign next_level = (s2 == s3) ? s3 : level;
   assign rise = next_level & ~level;
   assign fall = ~next_level & level;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         s1 <= INIT;
         s2 <= INIT;
         s3 <= INIT;
         level <= INIT;
      end else begin
         s1 <= pin;
         s2 <= s1;
         s3 <= s2;
         level <= next_level;
      end
   end

endmodule

`default_nettype wire

// ---- hdl/sadc_readout.sv ----
// sequencing and serial readout of an 8-bit successive-approximation converter
// Functional notes
// - select falling powers the analog section and starts the sequence.
// - each comparison result goes onto serial out at a clock fall.
// - bit is 1 when input exceeds the trial level, else 0.
// - eight-bit result, most significant bit first.
// - whole sequence ends within eleven serial clock periods.
// - select high floats serial out and keeps the analog section off.
// - select high holds the readout registers at reset: bit_idx at 7, all others cleared.
`timescale 1ns/1ps
`default_nettype none
`include "sadc_params.svh"

module sadc_readout #(
   parameter logic [3:0] LEAD = `SADC_LEAD_PERIODS
) (
   input wire logic ref_clk, // 25 MHz system clock
   input wire logic sys_rst, // synchronous reset, active high
   input wire sadc_pkg::sadc_pins_t pins, // host select and serial clock
   input wire logic comp_gt, // comparator: input above trial level
   output sadc_pkg::sadc_sout_t sout, // serial data and its enable
   output logic analog_en, // analog section power, high when on
   output logic [7:0] dac_trial, // trial level for the comparator
   output logic [7:0] result, // code decided so far, complete once conv_done is high
   output logic conv_done // high once the sequence is over
);
   import sadc_pkg::*;

   sadc_state_t state;
   sadc_state_t next_state;
   logic [3:0] fall_cnt;
   logic [2:0] bit_idx;
   logic sel_lvl;
   logic sel_fall;
   logic desel;
   logic sclk_fall;
   logic in_data;
   logic data_fall;
   logic last_bit;
   logic seq_end;
   logic [7:0] bit_mask;
   logic [7:0] next_code;
   logic [7:0] next_trial;

   function automatic logic [7:0] sadc_onehot(input logic [2:0] idx);
      sadc_onehot = 8'h01 << idx;
   endfunction

   sadc_pin_sync #(.INIT(`SADC_SEL_IDLE)) u_sel_sync (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .pin(pins.sel_n),
      .level(sel_lvl),
      .rise(),
      .fall(sel_fall)
   );

   sadc_pin_sync #(.INIT(`SADC_SCLK_IDLE)) u_sclk_sync (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .pin(pins.sclk),
      .level(),
      .rise(),
      .fall(sclk_fall)
   );

   // the accepted fall arrives while the filtered level is still high, so
   // the clear that select high forces must let that one cycle through
   assign desel = sel_lvl && !sel_fall;
   // periods before LEAD carry no data; the next eight carry the bits
   assign in_data = (fall_cnt >= LEAD) && (fall_cnt < LEAD + 4'h8);
   assign data_fall = (state == SADC_CONVERT) && sclk_fall && in_data;
   assign last_bit = (bit_idx == 3'h0);
   assign bit_mask = sadc_onehot(bit_idx);
   // keep the trial bit only when the input is above the trial level
   assign next_code = comp_gt ? dac_trial : (dac_trial & ~bit_mask);
   assign next_trial = last_bit ? next_code
                     : (next_code | sadc_onehot(bit_idx - 3'h1));
   assign seq_end = (state == SADC_CONVERT) && sclk_fall
                  && (fall_cnt == `SADC_CONV_PERIODS - 4'h1);

   always_comb begin
      case (state)
         SADC_SHUTDOWN:
            next_state = sel_fall ? SADC_CONVERT : SADC_SHUTDOWN;
         SADC_CONVERT:
            next_state = seq_end ? SADC_DONE : SADC_CONVERT;
         SADC_DONE:
            next_state = SADC_DONE;
         default:
            next_state = SADC_SHUTDOWN;
      endcase
   end

   // select high wins over everything: early release abandons the work
   always_ff @(posedge ref_clk) begin
      if (sys_rst || desel) begin
         state <= SADC_SHUTDOWN;
         fall_cnt <= `SADC_CNT_RESET;
         bit_idx <= `SADC_BIT_RESET;
      end else begin
         state <= next_state;
         if ((state == SADC_CONVERT) && sclk_fall) begin
            fall_cnt <= fall_cnt + 4'h1;
         end
         if (data_fall && !last_bit) begin
            bit_idx <= bit_idx - 3'h1;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst || desel) begin
         dac_trial <= `SADC_CODE_RESET;
         result <= `SADC_CODE_RESET;
         sout <= '0;
         analog_en <= 1'b0;
         conv_done <= 1'b0;
      end else begin
         if (sel_fall) begin
            dac_trial <= `SADC_MSB_MASK;
            analog_en <= 1'b1;
            sout.oe <= 1'b1;
         end else if (data_fall) begin
            dac_trial <= next_trial;
            result <= next_code;
            sout.data <= comp_gt;
         end
         if (seq_end) begin
            conv_done <= 1'b1;
         end
      end
   end

   // assertions
   logic [3:0] seen_falls;

   always_ff @(posedge ref_clk) begin
      if (sys_rst || desel) begin
         seen_falls <= 4'h0;
      end else if ((state != SADC_SHUTDOWN) && sclk_fall
                   && (seen_falls != 4'hf)) begin
         seen_falls <= seen_falls + 4'h1;
      end
   end

   sequence s_power_on;
      analog_en && sout.oe && (state == SADC_CONVERT);
   endsequence

   sequence s_released;
      !sout.oe && !analog_en && (state == SADC_SHUTDOWN);
   endsequence

   a_start_power_up: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (state == SADC_SHUTDOWN) && sel_fall |=> s_power_on)
      else $error("conversion did not start after select fell");

   a_bit_on_fall: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      sout.oe && $changed(sout.data) |-> $past(data_fall))
      else $error("serial out changed away from a clock fall");

   a_bit_value: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      data_fall && !sel_lvl |=> sout.data == $past(comp_gt))
      else $error("serial bit differs from comparator decision");

   a_msb_first: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      data_fall && !sel_lvl && (fall_cnt == LEAD)
      |=> (result[7] == $past(comp_gt)) && (bit_idx == 3'h6))
      else $error("first data bit was not the most significant");

   a_conv_bound: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (seen_falls >= `SADC_CONV_PERIODS) |-> conv_done)
      else $error("conversion ran past eleven clock periods");

   a_select_float: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      desel |=> s_released)
      else $error("output driven or analog on while deselected");

   a_regs_cleared: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      sel_lvl [*2] |-> (result == 8'h00) && (dac_trial == 8'h00)
      && (fall_cnt == 4'h0) && !conv_done)
      else $error("internal state not cleared while deselected");

   a_lead_quiet: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (state == SADC_CONVERT) && (fall_cnt < LEAD) |-> !data_fall
      && (bit_idx == 3'h7) && (result == 8'h00))
      else $error("data produced during leading periods");

   a_bit_lands: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      data_fall && !desel |=> result[$past(bit_idx)] == $past(comp_gt))
      else $error("result bit differs from comparator decision");

   a_done_holds: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      conv_done && !desel |=> conv_done && (state == SADC_DONE))
      else $error("finished conversion did not hold");

   a_no_early_done: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (state == SADC_CONVERT) && !seq_end |=> !conv_done)
      else $error("conversion flagged done before its last period");

   a_power_kept: assert property (
      @(posedge ref_clk) disable iff (sys_rst)
      (state != SADC_SHUTDOWN) && !desel |=> analog_en && sout.oe)
      else $error("analog section or output dropped during conversion");

endmodule

`default_nettype wire

// ---- test/sadc_host.sv ----
// host model: drives select and serial clock, samples serial data
`timescale 1ns/1ps
`default_nettype none

module sadc_host (
   input wire logic ref_clk, // system clock
   input wire sadc_pkg::sadc_sout_t sout, // serial data from the device
   output var sadc_pkg::sadc_pins_t pins // select and serial clock
);
   import sadc_pkg::*;

   initial pins = {1'b1, 1'b0};

   task automatic hold(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   // every select change is given 8 cycles, well over the filter delay
   task automatic select(input logic lvl);
      @(posedge ref_clk);
      pins.sel_n <= lvl;
      hold(8);
   endtask

   // one serial period: rise, then fall; each phase lasts 8 cycles
   task automatic tick(output logic bit_seen);
      @(posedge ref_clk);
      pins.sclk <= 1'b1;
      // a floating line reads as the inverse so a missing drive shows up
      bit_seen = sout.oe ? sout.data : ~sout.data;
      hold(8);
      pins.sclk <= 1'b0;
      hold(8);
   endtask
endmodule

`default_nettype wire

// ---- test/sadc_readout_bench.sv ----
// self-checking bench of the serial converter readout
`timescale 1ns/1ps
`default_nettype none
`include "sadc_params.svh"
`define SADC_CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin \
   num_errors++; $display("[FAIL] %s exp %h got %h", nm, ex, gt); end end

module sadc_readout_bench;
   import sadc_pkg::*;
   localparam int LEAD_N = 2;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] vin = 8'h00;
   sadc_pins_t pins;
   sadc_sout_t sout;
   logic analog_en, conv_done, comp_gt;
   logic [7:0] dac_trial, result;
   int num_errors = 0;
   int checks = 0;

   // comparator stand-in: strict greater-than against the trial level
   assign comp_gt = (vin > dac_trial);
   initial forever #20 ref_clk = ~ref_clk;

   sadc_readout #(.LEAD(4'(LEAD_N))) dut_u (.ref_clk(ref_clk),
      .sys_rst(sys_rst), .pins(pins), .comp_gt(comp_gt), .sout(sout),
      .analog_en(analog_en), .dac_trial(dac_trial), .result(result),
      .conv_done(conv_done));
   sadc_host host_u (.ref_clk(ref_clk), .sout(sout), .pins(pins));

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic wait_lvl(input logic lvl);
      int n;
      for (n = 0; n < 20 && !(conv_done === lvl && sout.oe === lvl); n++)
         @(posedge ref_clk);
      if (n == 20) begin
         num_errors++;
         $display("[FAIL] handshake exp %b got %b", lvl, conv_done);
         end_of_test();
      end
   endtask

   task automatic idle_check;
      `SADC_CHK("idle", 19'h0, {sout.oe, analog_en, dac_trial, result,
         conv_done})
   endtask

   // stop_at below 11 releases select early, after that many periods
   task automatic run_conv(input logic [7:0] v, input int stop_at);
      logic b;
      logic [7:0] got;
      logic [7:0] exp;
      int i;
      exp = (v == 8'h00) ? 8'h00 : v - 8'h01;
      got = 8'h00;
      vin <= v;
      host_u.select(1'b0);
      `SADC_CHK("power", 2'b11, {sout.oe, analog_en})
      `SADC_CHK("trial", 8'h80, dac_trial)
      for (i = 0; i < stop_at; i++) begin
         `SADC_CHK("early done", 1'b0, conv_done)
         host_u.tick(b);
         if (i > LEAD_N && i <= LEAD_N + 8)
            got = {got[6:0], b};
      end
      if (stop_at == 11) begin
         wait_lvl(1'b1);
         `SADC_CHK("serial", exp, got)
         `SADC_CHK("result", exp, result)
         host_u.tick(b);
         `SADC_CHK("hold", {1'b1, exp}, {conv_done, result})
      end
      host_u.select(1'b1);
      wait_lvl(1'b0);
      idle_check();
      host_u.tick(b);
      host_u.tick(b);
      idle_check();
      $display("test vin %h stop %0d done", v, stop_at);
   endtask

   initial begin
      repeat (20) @(posedge ref_clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge ref_clk);
      idle_check();
      run_conv(8'h00, 11);
      run_conv(8'h80, 11);
      run_conv(8'hff, 11);
      run_conv(8'h5a, 11);
      run_conv(8'h5a, 5);
      run_conv(8'h3c, 11);
      end_of_test();
   end
endmodule

`default_nettype wire
